// ==== design/vci_defs.vh ====
// register offsets, command and status codes and sizes of the command interface
// assumes apb byte addresses with one 32-bit word per register half
`ifndef VCI_DEFS_VH
`define VCI_DEFS_VH
`define VCI_CMD_LO      12'he00
`define VCI_CMD_HI      12'he04
`define VCI_EXT_LO      12'he08
`define VCI_EXT_HI      12'he0c
`define VCI_RSP_LO      12'he10
`define VCI_RSP_HI      12'he14
`define VCI_CTL         12'he40
`define VCI_POOL        12'he44
`define VCI_OP_NULL     8'h00
`define VCI_OP_ALLOC    8'h01
`define VCI_OP_FREE     8'h02
`define VCI_SC_OK       7'h00
`define VCI_SC_UNDEF    7'h01
`define VCI_SC_SPEC     7'h10
`define VCI_POOL_N      32
`define VCI_EXEC_CYC    2
`define VCI_CTL_RST     2'h3
`endif

// ==== design/vci_top.v ====
// apb slave for virtual command submission with a small pasid pool
// assumes one clock pclk, async active-low presetn, apb master outside
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "vci_defs.vh"

// Contract
// R1: command register at e00h: code 7:0, operand 63:16, bits 15:8 read zero
// R2: while in progress, writes to code, operand and extra operand are dropped
// R3: accepted code write clears response then sets in-progress
// R4: code 0 null, 1 allocate pasid, 2 free pasid, others reserved
// R5: free pasid takes the pasid from bits 35:16, ignores 63:36
// R6: extra operand register at e08h, 64 bits, unused by defined commands
// R7: without command support, both registers read zero and ignore writes
// R8: response at e10h, bit 0 in-progress, cleared on completion
// R9: status in response 7:1: zero success, one undefined command
// R10: allocate returns pasid in 35:16 or status 16; free invalid gives 16
// R11: reserved codes finish with undefined status, zero result, flag cleared
module vci_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         busy
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    reg [2:0]               state;
    reg [7:0]               cmd_code;
    reg [47:0]              first_operand;
    reg [63:0]              second_operand;
    reg                     in_progress_flag;
    reg [6:0]               completion_status;
    reg [47:0]              completion_result;
    reg                     virtual_command_support;
    reg                     free_support;
    reg [`VCI_POOL_N-1:0]   pool_used;
    reg [1:0]               exec_cnt;
    reg [4:0]               free_idx;
    reg                     free_found;
    reg [31:0]              rd_word;
    integer                 i;

    wire        acc     = psel & penable & ~pready;
    wire        wr      = acc & pwrite;
    wire        vcs_ok  = virtual_command_support;
    wire        open_wr = vcs_ok & ~in_progress_flag;                  // R2 R7
    wire [19:0] free_pasid = first_operand[19:0];                      // R5
    wire        wr_cmd_lo  = wr & open_wr & (paddr == `VCI_CMD_LO);    // R1 R2
    wire        wr_cmd_hi  = wr & open_wr & (paddr == `VCI_CMD_HI);    // R2
    wire        wr_ext_lo  = wr & open_wr & (paddr == `VCI_EXT_LO);    // R2 R6
    wire        wr_ext_hi  = wr & open_wr & (paddr == `VCI_EXT_HI);    // R6
    wire        wr_ctl     = wr & ~in_progress_flag & (paddr == `VCI_CTL);

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `VCI_CMD_LO) || (a == `VCI_CMD_HI) || (a == `VCI_EXT_LO) ||
                     (a == `VCI_EXT_HI) || (a == `VCI_RSP_LO) || (a == `VCI_RSP_HI) ||
                     (a == `VCI_CTL) || (a == `VCI_POOL);
        end
    endfunction

    always @*
    begin
        free_idx   = 5'h00;
        free_found = 1'b0;
        for (i = `VCI_POOL_N - 1; i >= 0; i = i - 1)
        begin
            if (!pool_used[i])
            begin
                free_idx   = i[4:0];
                free_found = 1'b1;
            end
        end
    end

    always @*
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `VCI_CMD_LO: rd_word = {first_operand[15:0], 8'h00, cmd_code};    // R1
            `VCI_CMD_HI: rd_word = first_operand[47:16];
            `VCI_EXT_LO: rd_word = second_operand[31:0];                      // R6
            `VCI_EXT_HI: rd_word = second_operand[63:32];
            `VCI_RSP_LO: rd_word = {completion_result[15:0], 8'h00,
                                    completion_status, in_progress_flag};      // R8
            `VCI_RSP_HI: rd_word = completion_result[47:16];
            `VCI_CTL:    rd_word = {30'h0, free_support, virtual_command_support};
            `VCI_POOL:   rd_word = pool_used;
            default:     rd_word = 32'h0000_0000;
        endcase
        if (!vcs_ok && paddr != `VCI_CTL && paddr != `VCI_POOL)
        begin
            rd_word = 32'h0000_0000;                                         // R7
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped(paddr);
            prdata  <= (acc & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_operand                          <= 64'h0;
            {free_support, virtual_command_support} <= `VCI_CTL_RST;
        end
        else
        begin
            if (wr_ctl)
            begin
                virtual_command_support <= pwdata[0];
                free_support            <= pwdata[1];
            end
            if (wr_ext_lo)
                second_operand[31:0]  <= pwdata;                       // R2 R6
            if (wr_ext_hi)
                second_operand[63:32] <= pwdata;                       // R2 R6
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state                   <= ST_IDLE;
            cmd_code                <= 8'h00;
            first_operand           <= 48'h0;
            in_progress_flag        <= 1'b0;
            completion_status       <= 7'h00;
            completion_result       <= 48'h0;
            pool_used               <= {`VCI_POOL_N{1'b0}};
            exec_cnt                <= 2'h0;
            busy                    <= 1'b0;
        end
        else
        begin
            if (wr_cmd_hi)
                first_operand[47:16] <= pwdata;                        // R2
            case (state)
                ST_IDLE:
                begin
                    if (wr_cmd_lo)
                    begin
                        cmd_code            <= pwdata[7:0];           // R1
                        first_operand[15:0] <= pwdata[31:16];
                        completion_status   <= 7'h00;                 // R3
                        completion_result   <= 48'h0;
                        in_progress_flag    <= 1'b1;                  // R3
                        busy                <= 1'b1;
                        exec_cnt            <= 2'd0;
                        state               <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    exec_cnt <= exec_cnt + 2'd1;
                    if (exec_cnt == (`VCI_EXEC_CYC - 1))
                        state <= ST_DONE;
                end
                ST_DONE:
                begin
                    case (cmd_code)                                   // R4
                        `VCI_OP_NULL: completion_status <= `VCI_SC_OK;
                        `VCI_OP_ALLOC:
                        begin
                            if (free_found)
                            begin
                                pool_used[free_idx] <= 1'b1;
                                completion_result   <= {28'h0, 15'h0, free_idx}; // R10
                                completion_status   <= `VCI_SC_OK;
                            end
                            else
                                completion_status <= `VCI_SC_SPEC;   // R10
                        end
                        `VCI_OP_FREE:
                        begin
                            if (!free_support)
                                completion_status <= `VCI_SC_UNDEF;  // R9
                            else if (free_pasid < `VCI_POOL_N && pool_used[free_pasid[4:0]])
                            begin
                                pool_used[free_pasid[4:0]] <= 1'b0;  // R5
                                completion_status <= `VCI_SC_OK;
                            end
                            else
                                completion_status <= `VCI_SC_SPEC;   // R10
                        end
                        default: completion_status <= `VCI_SC_UNDEF; // R9 R11
                    endcase
                    in_progress_flag <= 1'b0;                         // R8
                    busy             <= 1'b0;
                    state            <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule

// ==== tb/vci_assertions.sv ====
// port checker for the command interface
// assumes it is bound onto vci_top, one clock, async active-low reset
`timescale 1ns/1ps
module vci_chk
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        busy
);
    wire acc = psel && penable && !pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; acc |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_start; $rose(busy) |-> $past(acc && pwrite && paddr == 12'he00); endproperty
    a_start: assert property (p_start) else $error("command start without write");
    property p_end; $rose(busy) |-> busy ##[1:3] !busy; endproperty
    a_end: assert property (p_end) else $error("command never finished");
    property p_rsvd; pready && !pwrite && paddr == 12'he00 |-> prdata[15:8] == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_unm; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind vci_top vci_chk vci_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .busy);

// ==== tb/tb.sv ====
// self-checking bench for the command interface
// assumes vci_top with its bound checker, apb master driven at rising edges
`timescale 1ns/1ps
`include "vci_defs.vh"
module tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        busy;
    integer     bad_count = 0;
    integer     checks_done = 0;
    integer     cyc = 0;
    integer     i;
    reg  [31:0] r;
    reg         e;
    vci_top vci_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    initial forever #10 pclk = ~pclk;
    task conclude;
    begin
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t timeout", $time);
            conclude;
        end
    end
    task chk(input [31:0] s, input [31:0] x);
    begin
        checks_done = checks_done + 1;
        if (s !== x)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h want %h", $time, s, x);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
    end
    endtask
    task idle;
    begin
        psel <= 1'b0;
        @(posedge pclk);
    end
    endtask
    task wait_rsp(input [31:0] x);
    begin
        apb(1'b0, `VCI_RSP_LO, 32'h0);
        while (r[0] !== 1'b0) apb(1'b0, `VCI_RSP_LO, 32'h0);
        idle;
        chk(r, x);
        chk({31'h0, busy}, 32'h0);
    end
    endtask
    task cmd(input [31:0] d, input [31:0] x);
    begin
        apb(1'b1, `VCI_CMD_LO, d);
        idle;
        wait_rsp(x);
    end
    endtask
    task t_regs;
    begin
        apb(1'b0, `VCI_CMD_LO, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, `VCI_EXT_LO, 32'h5a5a_a5a5);
        apb(1'b1, `VCI_EXT_HI, 32'h0123_4567);
        apb(1'b0, `VCI_EXT_LO, 32'h0);
        chk(r, 32'h5a5a_a5a5);
        apb(1'b0, `VCI_EXT_HI, 32'h0);
        chk(r, 32'h0123_4567);
        apb(1'b0, 12'he20, 32'h0);
        idle;
        chk(e, 32'h1);
        cmd(32'hffff_ff03, 32'h2);
        apb(1'b0, `VCI_CMD_LO, 32'h0);
        idle;
        chk(r, 32'hffff_0003);
        cmd(32'h0000_00ff, 32'h2);
        cmd(32'h0, 32'h0);
    end
    endtask
    task t_pool;
    begin
        for (i = 0; i < 32; i = i + 1) cmd(32'h1, i << 16);
        cmd(32'h1, 32'h20);
        cmd(32'h0001_0002, 32'h0);
        cmd(32'h0001_0002, 32'h20);
        apb(1'b1, `VCI_CMD_HI, 32'hffff_fff0);
        cmd(32'h2, 32'h0);
        apb(1'b0, `VCI_POOL, 32'h0);
        idle;
        chk(r, 32'hffff_fffc);
    end
    endtask
    task t_busy;
    begin
        cmd(32'h0001_0002, 32'h20);
        apb(1'b1, `VCI_CMD_LO, 32'h1);
        chk({31'h0, busy}, 32'h1);
        apb(1'b0, `VCI_RSP_LO, 32'h0);
        idle;
        chk(r, 32'h1);
        wait_rsp(32'h0);
        apb(1'b1, `VCI_CMD_LO, 32'h1);
        apb(1'b1, `VCI_CMD_LO, 32'h3);
        idle;
        wait_rsp(32'h0001_0000);
        apb(1'b1, `VCI_CMD_LO, 32'h0);
        apb(1'b1, `VCI_EXT_LO, 32'h0000_0077);
        wait_rsp(32'h0);
        apb(1'b0, `VCI_EXT_LO, 32'h0);
        chk(r, 32'h5a5a_a5a5);
    end
    endtask
    task t_off;
    begin
        apb(1'b1, `VCI_CTL, 32'h1);
        cmd(32'h0002_0002, 32'h2);
        apb(1'b1, `VCI_CTL, 32'h0);
        apb(1'b1, `VCI_EXT_LO, 32'h77);
        apb(1'b0, `VCI_EXT_LO, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, `VCI_CMD_LO, 32'h0);
        idle;
        chk(r, 32'h0);
        apb(1'b1, `VCI_CTL, 32'h3);
        apb(1'b0, `VCI_EXT_LO, 32'h0);
        idle;
        chk(r, 32'h5a5a_a5a5);
    end
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_pool;
        t_busy;
        t_off;
        conclude;
    end
endmodule
